//--- shared/cfcs_defines.svh
`ifndef CFCS_DEFINES_SVH
`define CFCS_DEFINES_SVH

// Register word indices; the byte address is four times the index.
`define CFCS_OFF_WAVE_MODE   8'h0D
`define CFCS_OFF_ACC_MODE    8'h0F
`define CFCS_OFF_CAL_MODE    8'h3D
`define CFCS_OFF_IRQ_EN_ONE  8'hD9
`define CFCS_OFF_IRQ_EN_THR  8'hDB
`define CFCS_OFF_IRQ_ST_ONE  8'hDC
`define CFCS_OFF_IRQ_ST_THR  8'hDE
`define CFCS_OFF_WAVE1_H     8'hE2
`define CFCS_OFF_WAVE1_M     8'hE3
`define CFCS_OFF_WAVE1_L     8'hE4
`define CFCS_OFF_WAVE2_H     8'hE5
`define CFCS_OFF_WAVE2_M     8'hE6
`define CFCS_OFF_WAVE2_L     8'hE7

// Field positions.
`define CFCS_BIT_CHAN        7
`define CFCS_BIT_POLARITY    6
`define CFCS_BIT_FORCE_PH    0
`define CFCS_BIT_FORCE_NE    1
`define CFCS_BIT_FAULT       5
`define CFCS_BIT_WAVEFORM_SAMPLE_FLAG        5

// Reset values.
`define CFCS_RST_WAVE_MODE   8'h00
`define CFCS_RST_ACC_MODE    8'h00
`define CFCS_RST_CAL_MODE    8'h00
`define CFCS_RST_IRQ_EN      8'h00

// Converter codes and thresholds.
`define CFCS_SAT_POS         24'h400000
`define CFCS_SAT_NEG         24'hC00000
`define CFCS_FS_CODE         24'h28F5C2
`define CFCS_LIGHT_PERMILLE  64'h3
`define CFCS_MISMATCH_SHIFT  4
`define CFCS_VOLT_SHIFT      8

// Timing.
`define CFCS_CLK_MHZ         64'd200
`define CFCS_SAMPLE_DIV      160
`define CFCS_FAULT_AVG_MS    64'd1000
`define CFCS_FAULT_FLAG_MS   64'd3000
`define CFCS_AVG_SAMPLES     32'(`CFCS_FAULT_AVG_MS * 64'd1000 * `CFCS_CLK_MHZ / 64'd160)
`define CFCS_QUAL_WINDOWS    4'(`CFCS_FAULT_FLAG_MS / `CFCS_FAULT_AVG_MS)

`endif

//--- shared/cfcs_pkg.sv
package cfcs_pkg;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} cfcs_av_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} cfcs_av_rsp_t;

	typedef struct packed {
		logic [23:0] phase;
		logic [23:0] neutral;
		logic [23:0] volt;
	} cfcs_conv_t;

	typedef struct packed {
		logic        valid;
		logic        chan;
		logic [23:0] current;
		logic [23:0] volt;
	} cfcs_bill_t;

	typedef struct packed {
		cfcs_av_rsp_t rsp;
		cfcs_bill_t   bill;
		logic         irq;
		logic [7:0]   div_cnt;
		logic [2:0]   rate_cnt;
		logic [7:0]   wave_mode;
		logic [7:0]   acc_mode;
		logic [7:0]   cal_mode;
		logic [7:0]   en_one;
		logic [7:0]   en_three;
		logic [7:0]   st_one;
		logic [7:0]   st_three;
		logic [23:0]  live1;
		logic [23:0]  live2;
		logic [23:0]  lat1;
		logic [23:0]  lat2;
		logic [31:0]  win_cnt;
		logic [55:0]  sum_a;
		logic [55:0]  sum_b;
		logic         auto_ch;
		logic         fault;
		logic [3:0]   fault_q;
		logic [3:0]   swap_q;
		logic         win_done;
	} cfcs_state_t;

endpackage

//--- hdl/cfcs_top.sv
`timescale 1ns/100ps
`include "cfcs_defines.svh"
module cfcs_top #(
	parameter int unsigned AVG_SAMPLES  = `CFCS_AVG_SAMPLES,
	parameter logic [3:0]  QUAL_WINDOWS = `CFCS_QUAL_WINDOWS
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire cfcs_pkg::cfcs_av_req_t avs_req,
	output cfcs_pkg::cfcs_av_rsp_t      avs_rsp,
	input  wire cfcs_pkg::cfcs_conv_t   conv,
	output cfcs_pkg::cfcs_bill_t        bill,
	output logic                        meter_irq
);
	import cfcs_pkg::*;

	localparam logic [63:0] LIGHT_SUM =
		64'(`CFCS_FS_CODE) * `CFCS_LIGHT_PERMILLE / 64'd1000 * 64'(AVG_SAMPLES);

	cfcs_state_t s_r;
	cfcs_state_t s_nxt;
	logic        strobe;
	logic        wave_tick;
	logic        chan;
	logic [2:0]  rate_mask;
	logic [23:0] pa;
	logic [23:0] pb;
	logic [23:0] pv;
	logic [63:0] sa;
	logic [63:0] sb;
	logic [63:0] diff;
	logic [63:0] act;
	logic        fault_cond;
	logic        want_swap;
	logic        light;
	logic        win_end;
	logic [7:0]  rd;
	logic [7:0]  wd;

	function automatic logic [23:0] sat24(input logic [23:0] x);
		if ($signed(x) > $signed(`CFCS_SAT_POS))
			return `CFCS_SAT_POS;
		else if ($signed(x) < $signed(`CFCS_SAT_NEG))
			return `CFCS_SAT_NEG;
		return x;
	endfunction

	function automatic logic [55:0] abs56(input logic [23:0] x);
		return 56'(x[23] ? 24'(-x) : x);
	endfunction

	assign avs_rsp   = s_r.rsp;
	assign bill      = s_r.bill;
	assign meter_irq = s_r.irq;

	always_comb begin
		s_nxt = s_r;
		wd    = avs_req.writedata[7:0];
		rd    = 8'h00;
		// Base sample strobe at clock over 160.
		strobe = (s_r.div_cnt == 8'(`CFCS_SAMPLE_DIV - 1));
		s_nxt.div_cnt = strobe ? 8'h00 : s_r.div_cnt + 8'h01;
		pa = sat24(conv.phase);
		pb = sat24(conv.neutral);
		pv = 24'($signed(sat24(conv.volt)) >>> `CFCS_VOLT_SHIFT);
		// Forced choice only when exactly one force bit is set.
		if (s_r.cal_mode[`CFCS_BIT_FORCE_PH] && !s_r.cal_mode[`CFCS_BIT_FORCE_NE]) begin
			chan = 1'b0;
		end else if (!s_r.cal_mode[`CFCS_BIT_FORCE_PH] && s_r.cal_mode[`CFCS_BIT_FORCE_NE]) begin
			chan = 1'b1;
		end else begin
			chan = s_r.auto_ch;
		end
		// Billing feed runs on every base sample regardless of waveforms.
		s_nxt.bill.valid = strobe;
		if (strobe) begin
			s_nxt.bill.chan    = chan;
			s_nxt.bill.current = chan ? pb : pa;
			s_nxt.bill.volt    = pv;
			s_nxt.rate_cnt     = s_r.rate_cnt + 3'h1;
		end
		// Waveform decimation by 1, 2, 4 or 8.
		rate_mask = 3'((4'h1 << s_r.wave_mode[1:0]) - 4'h1);
		wave_tick = strobe && ((s_r.rate_cnt & rate_mask) == 3'h0);

		// Window sums of magnitudes for the fault comparison.
		sa         = 64'(s_r.sum_a);
		sb         = 64'(s_r.sum_b);
		diff       = (sa > sb) ? sa - sb : sb - sa;
		act        = chan ? sb : sa;
		fault_cond = (diff << `CFCS_MISMATCH_SHIFT) > act;
		if (s_r.auto_ch)
			want_swap = (sa > sb) && (((sa - sb) << `CFCS_MISMATCH_SHIFT) > sb);
		else
			want_swap = (sb > sa) && (((sb - sa) << `CFCS_MISMATCH_SHIFT) > sb);
		light = (sa < LIGHT_SUM) && (sb < LIGHT_SUM);
		// Decide on the full window sums in the same cycle as they restart.
		win_end        = strobe && (s_r.win_cnt == AVG_SAMPLES - 1);
		s_nxt.win_done = win_end;
		if (strobe) begin
			if (s_r.win_cnt == AVG_SAMPLES - 1) begin
				s_nxt.win_done = 1'b1;
				s_nxt.win_cnt  = 32'h0;
				s_nxt.sum_a    = abs56(pa);
				s_nxt.sum_b    = abs56(pb);
			end else begin
				s_nxt.win_cnt = s_r.win_cnt + 32'h1;
				s_nxt.sum_a   = s_r.sum_a + abs56(pa);
				s_nxt.sum_b   = s_r.sum_b + abs56(pb);
			end
		end

		// Bus: accept on the first edge, complete on the next.
		case (avs_req.address)
			`CFCS_OFF_WAVE_MODE:  rd = s_r.wave_mode;
			`CFCS_OFF_ACC_MODE:   rd = {chan, s_r.acc_mode[6:0]};
			`CFCS_OFF_CAL_MODE:   rd = s_r.cal_mode;
			`CFCS_OFF_IRQ_EN_ONE: rd = s_r.en_one;
			`CFCS_OFF_IRQ_EN_THR: rd = s_r.en_three;
			`CFCS_OFF_IRQ_ST_ONE: rd = s_r.st_one;
			`CFCS_OFF_IRQ_ST_THR: rd = s_r.st_three;
			`CFCS_OFF_WAVE1_H:    rd = s_r.live1[23:16];
			`CFCS_OFF_WAVE1_M:    rd = s_r.lat1[15:8];
			`CFCS_OFF_WAVE1_L:    rd = s_r.lat1[7:0];
			`CFCS_OFF_WAVE2_H:    rd = s_r.live2[23:16];
			`CFCS_OFF_WAVE2_M:    rd = s_r.lat2[15:8];
			`CFCS_OFF_WAVE2_L:    rd = s_r.lat2[7:0];
			default:              rd = 8'h00;
		endcase
		if ((avs_req.read || avs_req.write) && s_r.rsp.waitrequest) begin
			s_nxt.rsp.waitrequest = 1'b0;
			s_nxt.rsp.readdata    = avs_req.read ? {24'h0, rd} : 32'h0;
			if (avs_req.read && (avs_req.address == `CFCS_OFF_WAVE1_H ||
				avs_req.address == `CFCS_OFF_WAVE2_H)) begin
				s_nxt.lat1 = s_r.live1;
				s_nxt.lat2 = s_r.live2;
			end
		end else if (!s_r.rsp.waitrequest) begin
			s_nxt.rsp.waitrequest = 1'b1;
			s_nxt.rsp.readdata    = 32'h0;
			if (avs_req.write) begin
				case (avs_req.address)
					`CFCS_OFF_WAVE_MODE:  s_nxt.wave_mode = wd;
					`CFCS_OFF_ACC_MODE:   s_nxt.acc_mode = {1'b0, wd[6:0]};
					`CFCS_OFF_CAL_MODE:   s_nxt.cal_mode = wd;
					`CFCS_OFF_IRQ_EN_ONE: s_nxt.en_one = wd;
					`CFCS_OFF_IRQ_EN_THR: s_nxt.en_three = wd;
					`CFCS_OFF_IRQ_ST_ONE: s_nxt.st_one = s_r.st_one & ~wd;
					`CFCS_OFF_IRQ_ST_THR: s_nxt.st_three = s_r.st_three & ~wd;
					default:              s_nxt.rsp.readdata = 32'h0;
				endcase
			end
		end

		// Hardware events come after the clear so a set wins.
		if (wave_tick) begin
			s_nxt.live1 = chan ? pb : pa;
			s_nxt.live2 = pv;
			s_nxt.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] = 1'b1;
		end
		if (win_end) begin
			if (light) begin
				s_nxt.fault_q = 4'h0;
				s_nxt.swap_q  = 4'h0;
			end else begin
				if (fault_cond != s_r.fault) begin
					if (s_r.fault_q + 4'h1 >= QUAL_WINDOWS) begin
						s_nxt.fault   = fault_cond;
						s_nxt.fault_q = 4'h0;
						if (fault_cond != s_r.acc_mode[`CFCS_BIT_POLARITY])
							s_nxt.st_one[`CFCS_BIT_FAULT] = 1'b1;
					end else begin
						s_nxt.fault_q = s_r.fault_q + 4'h1;
					end
				end else begin
					s_nxt.fault_q = 4'h0;
				end
				if (want_swap) begin
					if (s_r.swap_q + 4'h1 >= QUAL_WINDOWS) begin
						s_nxt.auto_ch = !s_r.auto_ch;
						s_nxt.swap_q  = 4'h0;
						if (!s_r.acc_mode[`CFCS_BIT_POLARITY] && !s_r.auto_ch)
							s_nxt.st_one[`CFCS_BIT_FAULT] = 1'b1;
						if (s_r.acc_mode[`CFCS_BIT_POLARITY] && s_r.auto_ch)
							s_nxt.st_one[`CFCS_BIT_FAULT] = 1'b1;
					end else begin
						s_nxt.swap_q = s_r.swap_q + 4'h1;
					end
				end else begin
					s_nxt.swap_q = 4'h0;
				end
			end
		end
		s_nxt.irq = (s_nxt.st_one[`CFCS_BIT_FAULT] && s_nxt.en_one[`CFCS_BIT_FAULT]) ||
			(s_nxt.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] && s_nxt.en_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG]);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r                 <= '0;
			s_r.rsp.waitrequest <= 1'b1;
			s_r.wave_mode       <= `CFCS_RST_WAVE_MODE;
			s_r.acc_mode        <= `CFCS_RST_ACC_MODE;
			s_r.cal_mode        <= `CFCS_RST_CAL_MODE;
			s_r.en_one          <= `CFCS_RST_IRQ_EN;
			s_r.en_three        <= `CFCS_RST_IRQ_EN;
			s_r.auto_ch         <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Checking helpers.
	logic [7:0] gap_r;
	logic       seen_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gap_r  <= 8'h00;
			seen_r <= 1'b0;
		end else begin
			gap_r  <= s_r.bill.valid ? 8'h01 : gap_r + 8'h01;
			seen_r <= seen_r | s_r.bill.valid;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_accept_hi1;
		avs_req.read && avs_rsp.waitrequest && avs_req.address == `CFCS_OFF_WAVE1_H;
	endsequence

	sequence s_complete;
		!avs_rsp.waitrequest ##1 avs_rsp.waitrequest;
	endsequence

	sequence s_access;
		(avs_req.read || avs_req.write) && avs_rsp.waitrequest;
	endsequence

	property p_rate;
		bill.valid && seen_r && $past(seen_r) |-> gap_r == 8'(`CFCS_SAMPLE_DIV);
	endproperty
	a_rate: assert property (p_rate) else $error("billing sample spacing wrong");

	property p_sat;
		bill.valid |-> ($signed(bill.current) <= $signed(`CFCS_SAT_POS)) &&
			($signed(bill.current) >= $signed(`CFCS_SAT_NEG));
	endproperty
	a_sat: assert property (p_sat) else $error("current sample not saturated");

	property p_volt;
		bill.valid |-> (bill.volt[23:15] == 9'h000) || (bill.volt[23:15] == 9'h1FF);
	endproperty
	a_volt: assert property (p_volt) else $error("voltage sample not scaled");

	property p_latch;
		s_accept_hi1 |=> (s_r.lat1 == $past(s_r.live1)) &&
			(avs_rsp.readdata[7:0] == s_r.lat1[23:16]) ##0 s_complete;
	endproperty
	a_latch: assert property (p_latch) else $error("high byte read did not latch");

	property p_waveform_sample_flag_irq;
		s_r.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] && s_r.en_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] |-> meter_irq;
	endproperty
	a_waveform_sample_flag_irq: assert property (p_waveform_sample_flag_irq) else $error("waveform interrupt missing");

	property p_fault_irq;
		s_r.st_one[`CFCS_BIT_FAULT] && s_r.en_one[`CFCS_BIT_FAULT] |-> meter_irq;
	endproperty
	a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt missing");

	property p_flag_enter;
		$rose(s_r.fault) && !$past(s_r.acc_mode[`CFCS_BIT_POLARITY]) |->
			s_r.st_one[`CFCS_BIT_FAULT];
	endproperty
	a_flag_enter: assert property (p_flag_enter) else $error("fault entry not flagged");

	property p_power_up;
		$past(rst) |-> !s_r.auto_ch && !s_r.bill.chan;
	endproperty
	a_power_up: assert property (p_power_up) else $error("phase input not chosen");

	property p_force;
		s_r.cal_mode[`CFCS_BIT_FORCE_NE] && !s_r.cal_mode[`CFCS_BIT_FORCE_PH] && strobe
			|=> bill.valid && bill.chan;
	endproperty
	a_force: assert property (p_force) else $error("forced neutral input ignored");

	property p_swap_window;
		$changed(s_r.auto_ch) |-> s_r.win_done && !$past(light);
	endproperty
	a_swap_window: assert property (p_swap_window) else $error("swap outside window");

	property p_flag_hold;
		s_r.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] && !(avs_req.write && !avs_rsp.waitrequest)
			|=> s_r.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("waveform flag dropped");

	property p_answer;
		s_access |=> s_complete;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer not one cycle");

	property p_rdata_idle;
		avs_rsp.waitrequest |-> avs_rsp.readdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

	property p_acc_read;
		avs_req.read && avs_rsp.waitrequest && avs_req.address == `CFCS_OFF_ACC_MODE |=>
			(avs_rsp.readdata[7] == $past(chan)) && (avs_rsp.readdata[31:8] == 24'h0);
	endproperty
	a_acc_read: assert property (p_acc_read) else $error("channel indicator wrong");

	property p_force_ph;
		s_r.cal_mode[`CFCS_BIT_FORCE_PH] && !s_r.cal_mode[`CFCS_BIT_FORCE_NE] && strobe
			|=> bill.valid && !bill.chan;
	endproperty
	a_force_ph: assert property (p_force_ph) else $error("forced phase input ignored");

	property p_auto;
		(s_r.cal_mode[`CFCS_BIT_FORCE_PH] == s_r.cal_mode[`CFCS_BIT_FORCE_NE]) && strobe
			|=> bill.chan == $past(s_r.auto_ch);
	endproperty
	a_auto: assert property (p_auto) else $error("automatic choice not followed");

	property p_bill_pulse;
		bill.valid |=> !bill.valid;
	endproperty
	a_bill_pulse: assert property (p_bill_pulse) else $error("billing valid too long");

	property p_light;
		win_end && light |=> (s_r.fault_q == 4'h0) && (s_r.swap_q == 4'h0) &&
			$stable(s_r.fault) && $stable(s_r.auto_ch);
	endproperty
	a_light: assert property (p_light) else $error("decision taken at light load");

	property p_fault_win;
		$changed(s_r.fault) |-> s_r.win_done;
	endproperty
	a_fault_win: assert property (p_fault_win) else $error("fault change outside window");

	property p_waveform_sample_flag_set;
		wave_tick |=> s_r.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG];
	endproperty
	a_waveform_sample_flag_set: assert property (p_waveform_sample_flag_set) else $error("waveform flag not set");

	property p_irq_cause;
		meter_irq |-> (s_r.st_one[`CFCS_BIT_FAULT] && s_r.en_one[`CFCS_BIT_FAULT]) ||
			(s_r.st_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG] && s_r.en_three[`CFCS_BIT_WAVEFORM_SAMPLE_FLAG]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

	property p_keep_phase;
		win_end && !s_r.auto_ch && (sb <= sa) |=> !s_r.auto_ch;
	endproperty
	a_keep_phase: assert property (p_keep_phase) else $error("swap with phase larger");
endmodule

//--- tb/cfcs_conv_model.sv
`timescale 1ns/100ps
module cfcs_conv_model (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire cfcs_pkg::cfcs_conv_t lvl,
	output cfcs_pkg::cfcs_conv_t      conv
);
	import cfcs_pkg::*;
	logic [7:0] cnt_r;
	// Converter words refresh once per conversion period and hold in between.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= 8'h00;
			conv  <= '0;
		end else begin
			cnt_r <= (cnt_r == 8'h9F) ? 8'h00 : cnt_r + 8'h01;
			if (cnt_r == 8'h00) begin
				conv <= lvl;
			end
		end
	end
endmodule

//--- tb/tb_current_fault_channel_select.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_current_fault_channel_select;
	import cfcs_pkg::*;
	logic         clk_sys;
	logic         rst;
	cfcs_av_req_t req;
	cfcs_av_rsp_t rsp;
	cfcs_conv_t   lvl;
	cfcs_conv_t   conv;
	cfcs_bill_t   bill;
	logic         meter_irq;
	int           num_errors;
	int           checks_done;
	logic [31:0]  d;
	logic [23:0]  exp_v;
	logic [23:0]  ph_tab [4];
	time          t0;
	cfcs_top #(.AVG_SAMPLES(8), .QUAL_WINDOWS(4'h1)) DUT (.clk_sys(clk_sys), .rst(rst),
		.avs_req(req), .avs_rsp(rsp), .conv(conv), .bill(bill), .meter_irq(meter_irq));
	cfcs_conv_model u_conv (.clk_sys(clk_sys), .rst(rst), .lvl(lvl), .conv(conv));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	function automatic logic [23:0] sat24(input logic [23:0] x);
		if (!x[23] && x > 24'h400000) return 24'h400000;
		if (x[23] && x < 24'hC00000) return 24'hC00000;
		return x;
	endfunction
	task automatic final_report();
		$display("num_errors=%0d checks_done=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		req <= '{address: a, read: !w, write: w, writedata: {24'h000000, wd}};
		do begin
			@(posedge clk_sys);
		end while (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req <= '{address: 8'h00, read: 1'b0, write: 1'b0, writedata: 32'h0};
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		logic [31:0] x;
		bus(a, 1'b1, wd, x);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(a, 1'b0, 8'h00, d);
	endtask
	task automatic wait_bill(input int k);
		repeat (k) begin
			do @(posedge clk_sys); while (bill.valid !== 1'b1);
		end
	endtask
	task automatic wait_sig(input logic irq_lvl, input logic use_chan);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((use_chan ? bill.chan : meter_irq) !== irq_lvl && n < 20000);
		if (n >= 20000) num_errors++;
	endtask
	task automatic set_lvl(input logic [23:0] p, input logic [23:0] nu);
		@(posedge clk_sys);
		lvl.phase <= p;
		lvl.neutral <= nu;
		wait_bill(3);
	endtask
	initial begin
		#(5 * 90000);
		num_errors++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		req = '0;
		lvl = '{phase: 24'h100000, neutral: 24'h100000, volt: 24'h28F5C2};
		num_errors = 0;
		checks_done = 0;
		ph_tab = '{24'h28F5C2, 24'hD70A3E, 24'h500000, 24'hA00000};
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		void'($urandom(77975));
		foreach (ph_tab[i]) begin
			rd(i == 0 ? 8'h0D : i == 1 ? 8'h0F : i == 2 ? 8'h3D : 8'hD9);
			`CHK(d, 32'h0)
		end
		rd(8'h55);
		`CHK(d, 32'h0)
		wait_bill(1);
		`CHK(bill.chan, 1'b0)
		t0 = $time;
		wait_bill(1);
		`CHK($time - t0, 64'd800)
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			lvl.volt <= (i < 4) ? ph_tab[i] : 24'($urandom);
			set_lvl((i < 4) ? ph_tab[i] : 24'($urandom), 24'h100000);
			`CHK(bill.current, sat24(conv.phase))
			`CHK(bill.volt, 24'($signed(sat24(conv.volt)) >>> 8))
		end
		set_lvl(24'h123456, 24'h123456);
		wr(8'hDB, 8'h20);
		for (int r = 0; r < 4; r++) begin
			wr(8'h0D, 8'(r));
			wr(8'hDE, 8'h20);
			wait_sig(1'b0, 1'b0);
			wait_sig(1'b1, 1'b0);
			t0 = $time;
			wr(8'hDE, 8'h20);
			wait_sig(1'b0, 1'b0);
			wait_sig(1'b1, 1'b0);
			`CHK($time - t0, 64'(800 << r))
		end
		wr(8'hDB, 8'h00);
		wr(8'hDE, 8'h20);
		rd(8'hE2);
		`CHK(d, 32'h12)
		set_lvl(24'h654321, 24'h654321);
		rd(8'hE3);
		`CHK(d, 32'h34)
		rd(8'hE4);
		`CHK(d, 32'h56)
		exp_v = 24'($signed(sat24(lvl.volt)) >>> 8);
		rd(8'hE5);
		`CHK(d, {24'h000000, exp_v[23:16]})
		rd(8'hE6);
		`CHK(d, {24'h000000, exp_v[15:8]})
		rd(8'hE7);
		`CHK(d, {24'h000000, exp_v[7:0]})
		for (int k = 0; k < 4; k++) begin
			wr(8'h3D, 8'(k));
			set_lvl(24'h200000, 24'h210000);
			`CHK(bill.chan, k == 2)
			`CHK(bill.current, (k == 2) ? 24'h210000 : 24'h200000)
			rd(8'h0F);
			`CHK(d[7], k == 2)
		end
		wr(8'h3D, 8'h00);
		wr(8'h0F, 8'h80);
		rd(8'h0F);
		`CHK(d[7], 1'b0)
		set_lvl(24'h001000, 24'h000010);
		wr(8'hDC, 8'h20);
		repeat (4000) @(posedge clk_sys);
		rd(8'hDC);
		`CHK(d, 32'h0)
		wr(8'hD9, 8'h20);
		set_lvl(24'h200000, 24'h100000);
		wait_sig(1'b1, 1'b0);
		rd(8'hDC);
		`CHK(d[5], 1'b1)
		`CHK(bill.chan, 1'b0)
		wr(8'hDC, 8'h20);
		wait_sig(1'b0, 1'b0);
		set_lvl(24'h200000, 24'h300000);
		wait_sig(1'b1, 1'b1);
		wait_bill(2);
		`CHK(bill.current, 24'h300000)
		rd(8'hDC);
		`CHK(d[5], 1'b1)
		set_lvl(24'h310000, 24'h300000);
		repeat (4000) @(posedge clk_sys);
		`CHK(bill.chan, 1'b1)
		wr(8'h0F, 8'h40);
		wr(8'hDC, 8'h20);
		set_lvl(24'h400000, 24'h300000);
		wait_sig(1'b0, 1'b1);
		rd(8'hDC);
		`CHK(d[5], 1'b1)
		wr(8'hDC, 8'h20);
		wait_sig(1'b0, 1'b0);
		set_lvl(24'h300000, 24'h300000);
		wait_sig(1'b1, 1'b0);
		rd(8'hDC);
		`CHK(d[5], 1'b1)
		`CHK(bill.chan, 1'b0)
		final_report();
	end
endmodule
